// file: dtc_pkg.sv
// Shared constants and types for the dual timer/event counter block
`default_nettype none
package dtc_pkg;
    // APB geometry
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    // Register indexes; the byte address is four times the index
    localparam logic [5:0] CNT0_VAL_IDX = 6'h0d;
    localparam logic [5:0] CNT0_CTL_IDX = 6'h0e;
    localparam logic [5:0] CNT1_VAL_IDX = 6'h10;
    localparam logic [5:0] CNT1_CTL_IDX = 6'h11;
    localparam logic [5:0] IRQ_CTL_IDX = 6'h0b;
    localparam logic [5:0] PORTA_IDX = 6'h12;
    // Reset values
    localparam logic [7:0] CTL_RST = 8'h08;
    localparam logic [7:0] CNT_RST = 8'h00;
    localparam logic [1:0] FLAG_RST = 2'h0;
    localparam logic [1:0] IEN_RST = 2'h0;
    localparam logic [7:0] PORTA_RST = 8'hff;
    // Writable bits of each control register; unused bits stay zero
    localparam logic [7:0] CTL0_WMASK = 8'hdf;
    localparam logic [7:0] CTL1_WMASK = 8'hd8;
    // Field positions in the second interrupt control register
    localparam int IRQ_EN0_BIT = 0;
    localparam int IRQ_EN1_BIT = 1;
    localparam int IRQ_FLAG0_BIT = 4;
    localparam int IRQ_FLAG1_BIT = 5;
    // Port A bit that carries the frequency divider output
    localparam int PFD_PORT_BIT = 3;
    // Counting constants
    localparam logic [7:0] CNT_TOP = 8'hff;
    localparam int PRESCALE_W = 7;
    localparam int CNT1_DIV = 4;
    // Operating modes held in control bits 7:6
    typedef enum logic [1:0] {
        DTC_MODE_UNUSED = 2'h0,
        DTC_MODE_EVENT = 2'h1,
        DTC_MODE_TIMER = 2'h2,
        DTC_MODE_PULSE = 2'h3
    } dtc_mode_e;
    // Control register layout, bit 7 first
    typedef struct packed {
        dtc_mode_e mode;
        logic spare;
        logic run;
        logic edge_sel;
        logic [2:0] psc;
    } dtc_ctl_s;
    // Pulse-width measurement sequencer
    typedef enum logic [2:0] {
        PW_IDLE = 3'h1,
        PW_WAIT = 3'h2,
        PW_MEAS = 3'h4
    } dtc_pw_e;
    // Synchronised event pin with its edges
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } dtc_pin_s;
endpackage
`default_nettype wire

// file: dtc_pin_sync.sv
// Two-flop synchroniser and edge detector for one event pin
`default_nettype none
module dtc_pin_sync
    import dtc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    output dtc_pin_s pin_o
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // First flop feeds only the second; edges are taken from the later pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Edge pulses last one pclk cycle
    assign pin_o.level = sync_r;
    assign pin_o.rise = sync_r & ~last_r;
    assign pin_o.fall = ~sync_r & last_r;
endmodule
`default_nettype wire

// file: dtc_top.sv
// Dual 8-bit timer/event counter with APB registers, wake-up and divider output
// How it works
// - Counter 0 counts up, prescaled clock or pin
// - Counter 1 counts up, clock/4 or pin
// - Write sets preload; read returns live count
// - Bits 7:6 pick event, timer, pulse modes
// - Overflow reloads preload and sets flag bit
// - Pulse mode measures between edges, clears run
// - Result held until run set again
// - Pulse mode overflow also reloads and flags
// - Bit 3 picks counted edge, 1 falling
// - Run bit gates counting; hardware clears only pulse
// - Any overflow wakes the device from halt
// - Port bit enables divider output from chosen counter
// - Clear enable bit blocks that counter's interrupt
// - Stopped write loads counter; running only preload
// - Reading the count blocks its counting clock
// - Counter 0 prescale is two to field power
// - Counter 0 control bit 5 reads zero
// - Pulse width counted on internal clock only
// - Counter 1 control keeps bits 4,3,7:6 only
`default_nettype none
module dtc_top
    import dtc_pkg::*;
#(
    parameter bit PFD_FROM_CNT1 = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cnt0_pin,
    input wire logic cnt1_pin,
    output logic cnt0_irq_req,
    output logic cnt1_irq_req,
    output logic halt_wake,
    output logic port_a_bit3
);
    // Picks the rising or falling edge pulse
    function automatic logic pick_edge(input dtc_pin_s p, input logic take_fall);
        return take_fall ? p.fall : p.rise;
    endfunction

    // True on the last cycle of each prescaler period of 2**sel
    function automatic logic psc_hit(input logic [PRESCALE_W-1:0] cnt, input logic [2:0] sel);
        logic [PRESCALE_W-1:0] mask;
        mask = PRESCALE_W'((8'h01 << sel) - 8'h01);
        return (cnt & mask) == mask;
    endfunction

    dtc_ctl_s ctl_r [2];
    dtc_ctl_s ctl_nxt [2];
    logic [7:0] cnt_r [2];
    logic [7:0] cnt_nxt [2];
    logic [7:0] pre_r [2];
    dtc_pw_e pw_r [2];
    dtc_pw_e pw_nxt [2];
    dtc_pin_s pin_s [2];
    logic [1:0] flag_r;
    logic [1:0] ien_r;
    logic [7:0] porta_r;
    logic [PRESCALE_W-1:0] prescale_r;
    logic [APB_DW-1:0] prdata_r;
    logic pfd_r;
    logic pa3_r;
    logic [1:0] int_tick;
    logic [1:0] count_en;
    logic [1:0] ovf;
    logic [1:0] pw_done;
    logic [1:0] rd_blk;
    logic [1:0] wr_val;
    logic [1:0] wr_ctl;

    // Pin synchronisers, one per counter
    dtc_pin_sync u_sync0 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(cnt0_pin),
        .pin_o(pin_s[0])
    );
    dtc_pin_sync u_sync1 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(cnt1_pin),
        .pin_o(pin_s[1])
    );

    // APB address decode; zero-wait slave, unmapped or misaligned gives an error
    wire logic [5:0] reg_idx = paddr[APB_AW-1:2];
    wire logic aligned = paddr[1:0] == 2'h0;
    wire logic hit_val0 = aligned && reg_idx == CNT0_VAL_IDX;
    wire logic hit_ctl0 = aligned && reg_idx == CNT0_CTL_IDX;
    wire logic hit_val1 = aligned && reg_idx == CNT1_VAL_IDX;
    wire logic hit_ctl1 = aligned && reg_idx == CNT1_CTL_IDX;
    wire logic hit_irq = aligned && reg_idx == IRQ_CTL_IDX;
    wire logic hit_porta = aligned && reg_idx == PORTA_IDX;
    wire logic mapped = hit_val0 | hit_ctl0 | hit_val1 | hit_ctl1 | hit_irq | hit_porta;
    wire logic wr_acc = psel & penable & pwrite & mapped;
    wire logic rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_r;
    assign wr_val = {wr_acc & hit_val1, wr_acc & hit_val0};
    assign wr_ctl = {wr_acc & hit_ctl1, wr_acc & hit_ctl0};
    wire logic wr_irq = wr_acc & hit_irq;
    wire logic wr_porta = wr_acc & hit_porta;

    // Polling the count in a tight loop starves the counter; software must budget for the lost ticks
    // Count clock is held off through both phases of a count read
    assign rd_blk = {psel & ~pwrite & hit_val1, psel & ~pwrite & hit_val0};

    // Read mux; control bits never written stay zero, so unused bits read zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (hit_val0) begin
            rd_mux = cnt_r[0];
        end else if (hit_ctl0) begin
            rd_mux = ctl_r[0];
        end else if (hit_val1) begin
            rd_mux = cnt_r[1];
        end else if (hit_ctl1) begin
            rd_mux = ctl_r[1];
        end else if (hit_irq) begin
            rd_mux[IRQ_FLAG0_BIT] = flag_r[0];
            rd_mux[IRQ_FLAG1_BIT] = flag_r[1];
            rd_mux[IRQ_EN0_BIT] = ien_r[0];
            rd_mux[IRQ_EN1_BIT] = ien_r[1];
        end else if (hit_porta) begin
            rd_mux = porta_r;
        end
    end

    // Read data is captured in the setup cycle, when counting is already blocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (rd_setup) begin
            prdata_r <= {24'h000000, rd_mux};
        end
    end

    // One shared prescaler saves flops; a new prescale setting joins its running period
    // Free-running prescaler shared by both internal clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_r <= '0;
        end else begin
            prescale_r <= prescale_r + PRESCALE_W'(1);
        end
    end
    assign int_tick[0] = psc_hit(prescale_r, ctl_r[0].psc);
    assign int_tick[1] = prescale_r[1:0] == 2'(CNT1_DIV - 1);

    // Per-counter tick selection, reload, measurement sequencer and control
    for (genvar c = 0; c < 2; c++) begin : g_ch
        wire logic ev_edge = pick_edge(pin_s[c], ctl_r[c].edge_sel);
        wire logic pw_start = pick_edge(pin_s[c], ~ctl_r[c].edge_sel);
        wire logic pw_stop = pick_edge(pin_s[c], ctl_r[c].edge_sel);
        wire logic in_pulse = ctl_r[c].run && ctl_r[c].mode == DTC_MODE_PULSE;
        logic src_tick;

        // Mode picks pin edges or the internal clock
        always_comb begin
            case (ctl_r[c].mode)
                DTC_MODE_EVENT: src_tick = ev_edge;
                DTC_MODE_TIMER: src_tick = int_tick[c];
                DTC_MODE_PULSE: src_tick = pw_r[c] == PW_MEAS && int_tick[c];
                default: src_tick = 1'b0;
            endcase
        end
        assign count_en[c] = ctl_r[c].run & src_tick & ~rd_blk[c];
        assign ovf[c] = count_en[c] && cnt_r[c] == CNT_TOP;
        assign pw_done[c] = in_pulse && pw_r[c] == PW_MEAS && pw_stop;

        // Measurement waits for the start edge only after run is set
        always_comb begin
            pw_nxt[c] = pw_r[c];
            case (pw_r[c])
                PW_IDLE: if (in_pulse) pw_nxt[c] = PW_WAIT;
                PW_WAIT: begin
                    if (!in_pulse) begin
                        pw_nxt[c] = PW_IDLE;
                    end else if (pw_start) begin
                        pw_nxt[c] = PW_MEAS;
                    end
                end
                PW_MEAS: if (!in_pulse || pw_stop) pw_nxt[c] = PW_IDLE;
                default: pw_nxt[c] = PW_IDLE;
            endcase
        end

        // Software write wins over the hardware run clear in the same cycle
        always_comb begin
            ctl_nxt[c] = ctl_r[c];
            if (wr_ctl[c]) begin
                ctl_nxt[c] = pwdata[7:0] & (c == 0 ? CTL0_WMASK : CTL1_WMASK);
            end else if (pw_done[c]) begin
                ctl_nxt[c].run = 1'b0;
            end
        end

        // Stopped write loads the count; a running counter keeps counting
        always_comb begin
            if (wr_val[c] && !ctl_r[c].run) begin
                cnt_nxt[c] = pwdata[7:0];
            end else if (ovf[c]) begin
                cnt_nxt[c] = pre_r[c];
            end else if (count_en[c]) begin
                cnt_nxt[c] = cnt_r[c] + 8'h01;
            end else begin
                cnt_nxt[c] = cnt_r[c];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ctl_r[c] <= CTL_RST;
                cnt_r[c] <= CNT_RST;
                pre_r[c] <= CNT_RST;
                pw_r[c] <= PW_IDLE;
            end else begin
                ctl_r[c] <= ctl_nxt[c];
                cnt_r[c] <= cnt_nxt[c];
                pw_r[c] <= pw_nxt[c];
                if (wr_val[c]) pre_r[c] <= pwdata[7:0];
            end
        end
    end

    // A written one also sets a flag, which lets software exercise the request path
    // Overflow flags are sticky; an overflow in the write cycle beats the clear
    wire logic [1:0] flag_nxt = (wr_irq ? {pwdata[IRQ_FLAG1_BIT], pwdata[IRQ_FLAG0_BIT]} : flag_r) | ovf;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= FLAG_RST;
            ien_r <= IEN_RST;
            porta_r <= PORTA_RST;
        end else begin
            flag_r <= flag_nxt;
            if (wr_irq) ien_r <= {pwdata[IRQ_EN1_BIT], pwdata[IRQ_EN0_BIT]};
            if (wr_porta) porta_r <= pwdata[7:0];
        end
    end

    // Request to the core only where the enable bit is set
    assign cnt0_irq_req = flag_r[0] & ien_r[0];
    assign cnt1_irq_req = flag_r[1] & ien_r[1];
    // Wake pulse is independent of the enables; the core decides what follows
    assign halt_wake = |ovf;

    // Divider halves the chosen overflow rate; port bit 3 gates it onto the pin
    wire logic pfd_ovf = PFD_FROM_CNT1 ? ovf[1] : ovf[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pfd_r <= 1'b0;
            pa3_r <= 1'b0;
        end else begin
            if (pfd_ovf) pfd_r <= ~pfd_r;
            pa3_r <= porta_r[PFD_PORT_BIT] & pfd_r;
        end
    end
    assign port_a_bit3 = pa3_r;

    // Checks on the counting, flag and register behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_overflow_reload: assert property (ovf[0] && !wr_val[0] |=> cnt_r[0] == $past(pre_r[0]) && flag_r[0])
        else $error("counter 0 overflow did not reload or flag");
    a_read_blocks: assert property (rd_blk[0] |=> $stable(cnt_r[0]))
        else $error("counter 0 advanced during a count read");
    a_stopped_hold: assert property (!ctl_r[1].run && !wr_val[1] |=> $stable(cnt_r[1]))
        else $error("stopped counter 1 changed");
    a_stopped_load: assert property (wr_val[0] && !ctl_r[0].run |=> cnt_r[0] == $past(pwdata[7:0])
        && pre_r[0] == $past(pwdata[7:0]))
        else $error("stopped write did not load counter and preload");
    a_running_write: assert property (wr_val[0] && ctl_r[0].run && !count_en[0] |=> $stable(cnt_r[0]))
        else $error("running write disturbed the count");
    a_pulse_end: assert property (pw_done[0] && !wr_ctl[0] |=> !ctl_r[0].run ##1 $stable(cnt_r[0]))
        else $error("pulse end did not stop counter 0");
    a_ctl0_spare: assert property (rd_setup && hit_ctl0 |=> prdata[5] == 1'b0)
        else $error("unused control bit read as one");
    a_irq_gated: assert property (!ien_r[0] |-> !cnt0_irq_req)
        else $error("masked counter raised a request");
    a_flag_sticky: assert property (flag_r[1] && !wr_irq |=> flag_r[1])
        else $error("overflow flag cleared without a write");
    a_wake_ovf: assert property (ovf[0] || ovf[1] |-> halt_wake)
        else $error("overflow gave no wake pulse");
    a_timer_div4: assert property (ctl_r[1].run && ctl_r[1].mode == DTC_MODE_TIMER && count_en[1]
        |=> !count_en[1] [*3] ##1 (count_en[1] || !ctl_r[1].run || rd_blk[1]))
        else $error("counter 1 timer rate is not clock/4");

    // Second counter: reload, read blocking, preload, run bit, event edge and unused control bits
    a_overflow_reload1: assert property (ovf[1] && !wr_val[1] |=> cnt_r[1] == $past(pre_r[1]) && flag_r[1])
        else $error("counter 1 overflow did not reload or flag");
    a_read_blocks1: assert property (rd_blk[1] |=> $stable(cnt_r[1]))
        else $error("counter 1 advanced during a count read");
    a_preload_write: assert property (wr_val[1] |=> pre_r[1] == $past(pwdata[7:0]))
        else $error("count write missed the preload");
    a_run_kept: assert property (ctl_r[1].run && ctl_r[1].mode != DTC_MODE_PULSE && !wr_ctl[1]
        |=> ctl_r[1].run)
        else $error("run bit cleared outside pulse mode");
    a_event_edge: assert property (ctl_r[1].run && ctl_r[1].mode == DTC_MODE_EVENT && !rd_blk[1]
        && pin_s[1].rise |-> count_en[1] == !ctl_r[1].edge_sel)
        else $error("event counter took the wrong edge");
    a_ctl1_unused: assert property (rd_setup && hit_ctl1 |=> prdata[5] == 1'b0 && prdata[2:0] == 3'h0)
        else $error("unused counter 1 control bits read as one");

    // First counter: prescale, pulse-width window and held result
    a_prescale_two: assert property (ctl_r[0].mode == DTC_MODE_TIMER && ctl_r[0].psc == 3'h1 && count_en[0]
        ##1 ctl_r[0].mode == DTC_MODE_TIMER && ctl_r[0].psc == 3'h1 |-> !count_en[0])
        else $error("counter 0 ticked twice in a divide-by-two period");
    a_pulse_count: assert property (ctl_r[0].mode == DTC_MODE_PULSE && count_en[0]
        |-> pw_r[0] == PW_MEAS && int_tick[0])
        else $error("pulse width counted outside the internal clock window");
    a_pulse_held: assert property (ctl_r[0].mode == DTC_MODE_PULSE && !ctl_r[0].run && !wr_val[0]
        |=> $stable(cnt_r[0]))
        else $error("held pulse result changed");

    // Requests and the divider pin follow their gates
    a_irq_gated1: assert property (!ien_r[1] |-> !cnt1_irq_req)
        else $error("masked counter 1 raised a request");
    a_req_follows: assert property (flag_r[0] && ien_r[0] |-> cnt0_irq_req)
        else $error("enabled counter 0 flag gave no request");
    a_pfd_gated: assert property (!porta_r[PFD_PORT_BIT] |=> !port_a_bit3)
        else $error("divider output seen with its port bit clear");

    c_ovf0: cover property (ovf[0]);
    c_pulse_done: cover property (pw_done[0] ##[1:20] wr_ctl[0]);
    c_pfd_toggle: cover property (porta_r[PFD_PORT_BIT] && $rose(port_a_bit3));
    c_event_cnt: cover property (ctl_r[1].mode == DTC_MODE_EVENT && count_en[1]);
    // A preload write that lands while the counter runs
    c_running_write: cover property (wr_val[0] && ctl_r[0].run);
endmodule
`default_nettype wire

// file: dtc_pin_src.sv
// Event and pulse source that stands in for the signals on both counter pins
`default_nettype none
module dtc_pin_src;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic pin0 = 1'b0;
    logic pin1 = 1'b0;
    // Drive one pin to a level just after a clock edge; the source never floats
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge pclk);
        if (idx == 0) begin
            pin0 <= lvl;
        end else begin
            pin1 <= lvl;
        end
    endtask
    // One pulse of a given level lasting a whole number of clock cycles
    task automatic pulse(input int idx, input logic lvl, input int width);
        set_pin(idx, lvl);
        repeat (width - 1) @(posedge pclk);
        set_pin(idx, ~lvl);
    endtask
endmodule
`default_nettype wire

// file: dtc_top_tb.sv
// Self-checking testbench for the dual timer/event counter over APB
`default_nettype none
module dtc_top_tb;
    import dtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 8'h00;
    logic [APB_DW-1:0] pwdata = 32'h0;
    logic [APB_DW-1:0] prdata;
    logic pready, pslverr, cnt0_irq_req, cnt1_irq_req, halt_wake, port_a_bit3;
    int num_errors = 0;
    int checks = 0;
    logic [7:0] rd, v;
    logic err, pa0;
    int n;
    // 25 MHz clock
    always #20 pclk = ~pclk;
    always @(pclk) drv_i.pclk = pclk;
    dtc_pin_src drv_i();
    dtc_top dtc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cnt0_pin(drv_i.pin0), .cnt1_pin(drv_i.pin1), .cnt0_irq_req(cnt0_irq_req),
        .cnt1_irq_req(cnt1_irq_req), .halt_wake(halt_wake), .port_a_bit3(port_a_bit3));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Range compare, for counts whose edge alignment the pins leave open by one tick
    task automatic chk_rng(input string nm, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] g);
        checks++;
        if (!(g >= lo && g <= hi) || $isunknown(g)) begin
            num_errors++;
            $display("wrong value %s expected %h..%h seen %h", nm, lo, hi, g);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [7:0] d, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        logic e;
        apb(1'b1, idx, wd, d, e);
    endtask
    task automatic rdchk(input string nm, input logic [5:0] idx, input logic [7:0] exp);
        logic e;
        apb(1'b0, idx, 8'h00, rd, e);
        chk(nm, {24'h0, exp}, {24'h0, rd});
    endtask
    // Wait for the next overflow pulse, counting the clock edges it took
    task automatic wait_wake(output int k);
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (halt_wake !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            num_errors++;
            $display("wrong value wake expected 1 seen 0");
        end
    endtask
    // Watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        repeat (60000) @(posedge pclk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctl0 reset", CNT0_CTL_IDX, CTL_RST);
        rdchk("ctl1 reset", CNT1_CTL_IDX, CTL_RST);
        rdchk("port reset", PORTA_IDX, PORTA_RST);
        apb(1'b0, 6'h00, 8'h00, rd, err);
        chk("unmapped err", 32'h1, {31'h0, err});
        // Unused control bits are dropped on write
        wr(CNT0_CTL_IDX, 8'h2f);
        rdchk("ctl0 spare", CNT0_CTL_IDX, 8'h0f);
        wr(CNT1_CTL_IDX, 8'h27);
        rdchk("ctl1 spare", CNT1_CTL_IDX, 8'h00);
        // Preload before first enable, loaded straight into a stopped counter
        wr(CNT0_VAL_IDX, 8'hfe);
        rdchk("stopped load", CNT0_VAL_IDX, 8'hfe);
        // Timer mode, every prescale step: two ticks per overflow
        for (int p = 0; p < 8; p++) begin
            wr(CNT0_CTL_IDX, {5'b10010, p[2:0]});
            wait_wake(n);
            pa0 = port_a_bit3;
            wait_wake(n);
            chk("c0 period", 32'(2 << p), 32'(n));
            chk("pfd toggle", {31'h0, ~pa0}, {31'h0, port_a_bit3});
        end
        // Running write at divide by two: only the preload takes it, the next overflow reloads it
        wr(CNT0_CTL_IDX, 8'h91);
        wait_wake(n);
        wr(CNT0_VAL_IDX, 8'h00);
        wait_wake(n);
        chk("running write", 32'h1, 32'(n));
        wait_wake(n);
        chk("new preload", 32'h200, 32'(n));
        // Clearing the port bit silences the divider output
        wr(PORTA_IDX, 8'hf7);
        for (int i = 0; i < 3; i++) begin
            wait_wake(n);
            chk("pfd off", 32'h0, {31'h0, port_a_bit3});
        end
        wr(CNT0_CTL_IDX, 8'h80);
        wr(PORTA_IDX, 8'hff);
        // Counter 1 runs from clock divided by four
        wr(CNT1_VAL_IDX, 8'hfe);
        wr(CNT1_CTL_IDX, 8'h90);
        wait_wake(n);
        wait_wake(n);
        chk("c1 period", 32'(2 * CNT1_DIV), 32'(n));
        wr(CNT1_CTL_IDX, 8'h80);
        rdchk("flags", IRQ_CTL_IDX, 8'h30);
        chk("req0 masked", 32'h0, {31'h0, cnt0_irq_req});
        wr(IRQ_CTL_IDX, 8'h33);
        @(posedge pclk);
        chk("req0", 32'h1, {31'h0, cnt0_irq_req});
        chk("req1", 32'h1, {31'h0, cnt1_irq_req});
        wr(IRQ_CTL_IDX, 8'h30);
        @(posedge pclk);
        chk("req1 masked", 32'h0, {31'h0, cnt1_irq_req});
        wr(IRQ_CTL_IDX, 8'h00);
        // Event mode on counter 1, each edge select; a stopped counter ignores the pin
        wr(CNT1_VAL_IDX, 8'h10);
        v = 8'h10;
        for (int s = 0; s < 2; s++) begin
            wr(CNT1_CTL_IDX, 8'h50 | 8'(s << 3));
            drv_i.set_pin(1, 1'b1);
            repeat (8) @(posedge pclk);
            v = v + 8'(s == 0);
            rdchk("rise count", CNT1_VAL_IDX, v);
            drv_i.set_pin(1, 1'b0);
            repeat (8) @(posedge pclk);
            v = v + 8'(s == 1);
            rdchk("fall count", CNT1_VAL_IDX, v);
        end
        wr(CNT1_CTL_IDX, 8'h48);
        drv_i.pulse(1, 1'b1, 6);
        repeat (8) @(posedge pclk);
        rdchk("stopped event", CNT1_VAL_IDX, v);
        // Pulse width on counter 0, both polarities, with an overflow mid-pulse
        for (int s = 1; s >= 0; s--) begin
            drv_i.set_pin(0, ~s[0]);
            wr(CNT0_CTL_IDX, 8'(s << 3));
            wr(CNT0_VAL_IDX, 8'hf0);
            wr(IRQ_CTL_IDX, 8'h00);
            wr(CNT0_CTL_IDX, 8'hd0 | 8'(s << 3));
            repeat (6) @(posedge pclk);
            drv_i.pulse(0, s[0], 20);
            repeat (8) @(posedge pclk);
            rdchk("run cleared", CNT0_CTL_IDX, 8'hc0 | 8'(s << 3));
            apb(1'b0, CNT0_VAL_IDX, 8'h00, v, err);
            chk_rng("width", 8'hf3, 8'hf5, v);
            rdchk("pulse flag", IRQ_CTL_IDX, 8'h10);
            drv_i.pulse(0, s[0], 20);
            repeat (8) @(posedge pclk);
            rdchk("held result", CNT0_VAL_IDX, v);
            wr(CNT0_CTL_IDX, 8'hd0 | 8'(s << 3));
            repeat (6) @(posedge pclk);
            drv_i.pulse(0, s[0], 10);
            repeat (8) @(posedge pclk);
            apb(1'b0, CNT0_VAL_IDX, 8'h00, rd, err);
            chk_rng("rearmed", v + 8'd9, v + 8'd11, rd);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
